// ### design/dpsd_scan_drive.sv
// Purpose: Buffer memories, scanner, selectors and digit drivers for a decimal printer
// Assumes: Inputs synchronous to clk; scan command held at least the minimum time
// Notes: Decade 0 is most significant; two selectors serve decades 0-2 and 3-5
`default_nettype none
module dpsd_scan_drive #(
   parameter int STEP_CYCLES = dpsd_pkg::STEP_CYC,
   parameter int NUM_DECADES = 3
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [dpsd_pkg::DECADES*dpsd_pkg::DIGITS-1:0] count_n,
   input wire logic transfer,
   input wire logic buffer_bypass,
   input wire logic scan_cmd,
   output dpsd_pkg::dpsd_prn_t prn,
   output logic busy,
   output logic [dpsd_pkg::DECADES-1:0] drive_enable
);
   localparam int D = dpsd_pkg::DECADES;
   localparam int N = dpsd_pkg::DIGITS;

   // Tick counter width sized for the step period
   localparam int TW = $clog2(STEP_CYCLES + 1);

   logic [D*N-1:0] held_n_r;
   logic transfer_q_r;
   logic scan_q_r;
   logic [D:0] step_r;
   logic [D:0] step_nxt;
   logic [TW-1:0] tick_cnt_r;
   dpsd_pkg::dpsd_state_t state_r;
   dpsd_pkg::dpsd_state_t state_nxt;
   dpsd_pkg::dpsd_prn_t prn_r;
   dpsd_pkg::dpsd_prn_t prn_nxt;

   wire transfer_rise = transfer & ~transfer_q_r;
   wire scan_rise = scan_cmd & ~scan_q_r;
   wire scan_fall = ~scan_cmd & scan_q_r;
   wire tick = (state_r == dpsd_pkg::DPSD_RUN) && (tick_cnt_r == TW'(STEP_CYCLES - 1));
   wire half = (state_r == dpsd_pkg::DPSD_RUN) && (tick_cnt_r < TW'(STEP_CYCLES / 2));

   // Selects each unit sees, active low; gate is low during first half period
   wire gate_n = ~half;
   wire [D-1:0] scan_sel_n = ~step_r[D-1:0];
   wire [2:0] scan_select_first_n = scan_sel_n[2:0];
   wire [2:0] scan_select_second_n = scan_sel_n[5:3];
   // Shared gated clock: one clock stage drives both link terminals
   wire clock_control_stage = gate_n;
   wire clock_link_first = clock_control_stage;
   wire clock_link_second = clock_link_first;

   function automatic logic [2:0] dpsd_select(input logic gate, input logic [2:0] sel_n);
      dpsd_select = {3{~gate}} & ~sel_n;
   endfunction : dpsd_select

   // Only configured decades may be enabled
   wire [D-1:0] present = D'((1 << NUM_DECADES) - 1);
   wire [D-1:0] enable_raw = {dpsd_select(clock_link_second, scan_select_second_n),
                              dpsd_select(clock_link_second, scan_select_first_n)};
   wire [D-1:0] enable = enable_raw & present;

   // Digit source: held buffer or direct counter lines
   wire [D*N-1:0] src_n = buffer_bypass ? count_n : held_n_r;

   // Wired-together arm lines of all drivers
   logic [N-1:0] arms;
   always_comb begin
      arms = dpsd_pkg::ARMS_IDLE;
      for (int d = 0; d < D; d++) begin
         if (enable[d]) begin
            arms = arms | ~src_n[d*N +: N];
         end
      end
   end

   // Scanner sequencing; step_r is one-hot while running and zero otherwise, bit D marks the print step
   always_comb begin
      state_nxt = state_r;
      step_nxt = step_r;
      unique case (state_r)
         dpsd_pkg::DPSD_IDLE: begin
            if (scan_rise) begin
               state_nxt = dpsd_pkg::DPSD_ARM;
               step_nxt = dpsd_pkg::STEP_RESET;
            end
         end
         dpsd_pkg::DPSD_ARM: begin
            if (scan_fall) begin
               state_nxt = dpsd_pkg::DPSD_RUN;
               step_nxt = (D+1)'(1);
            end
         end
         dpsd_pkg::DPSD_RUN: begin
            if (scan_rise) begin
               state_nxt = dpsd_pkg::DPSD_ARM;
               step_nxt = dpsd_pkg::STEP_RESET;
            end else if (tick) begin
               if (step_r[D]) begin
                  state_nxt = dpsd_pkg::DPSD_IDLE;
                  step_nxt = dpsd_pkg::STEP_RESET;
               end else if (step_r[NUM_DECADES-1]) begin
                  step_nxt = (D+1)'(1) << D;
               end else begin
                  step_nxt = step_r << 1;
               end
            end
         end
         default: begin
            state_nxt = dpsd_pkg::DPSD_IDLE;
            step_nxt = dpsd_pkg::STEP_RESET;
         end
      endcase
   end

   // Printer outputs; write strobe a quarter of the way into a digit step, in its first half
   always_comb begin
      prn_nxt.arm = arms;
      prn_nxt.write = (|enable) && (tick_cnt_r == TW'(STEP_CYCLES / 4));
      prn_nxt.print = step_r[D] && half;
   end

   // Buffer memory per decade
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         held_n_r <= {D{dpsd_pkg::DIGIT_IDLE}};
         transfer_q_r <= 1'b0;
      end else begin
         transfer_q_r <= transfer;
         if (!transfer) begin
            held_n_r <= {D{dpsd_pkg::DIGIT_IDLE}};
         end else if (transfer_rise) begin
            held_n_r <= count_n;
         end
      end
   end

   // Scanner registers and oscillator tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= dpsd_pkg::DPSD_IDLE;
         step_r <= dpsd_pkg::STEP_RESET;
         scan_q_r <= 1'b0;
         tick_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         scan_q_r <= scan_cmd;
         if (state_r != dpsd_pkg::DPSD_RUN || tick) begin
            tick_cnt_r <= '0;
         end else begin
            tick_cnt_r <= tick_cnt_r + TW'(1);
         end
      end
   end

   // Registered printer outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prn_r <= '0;
      end else begin
         prn_r <= prn_nxt;
      end
   end

   assign prn = prn_r;
   assign busy = (state_r != dpsd_pkg::DPSD_IDLE);
   assign drive_enable = enable;
endmodule : dpsd_scan_drive
`default_nettype wire

// ### design/dpsd_pkg.sv
// Purpose: Constants and types for the decimal printer scan drive
// Assumes: 10 MHz clock, six decades at most, one-of-ten active-low digits
`default_nettype none
package dpsd_pkg;
   localparam int DECADES = 6;
   localparam int DIGITS = 10;
   localparam int SEL_PER_UNIT = 3;
   localparam int CLK_NS = 100;
   localparam int SCAN_MIN_US = 100;
   localparam int SCAN_MIN_CYC = (SCAN_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STEP_MS = 100;
   localparam int STEP_CYC = STEP_MS * 1000000 / CLK_NS;
   localparam logic [9:0] DIGIT_IDLE = 10'h3FF;
   localparam logic [9:0] ARMS_IDLE = 10'h000;
   localparam logic [DECADES:0] STEP_RESET = '0;

   typedef logic [DIGITS-1:0] dpsd_digit_t;

   // Outputs towards the printer
   typedef struct packed {
      logic [DIGITS-1:0] arm;
      logic write;
      logic print;
   } dpsd_prn_t;

   typedef enum logic [2:0] {
      DPSD_IDLE = 3'b001,
      DPSD_ARM = 3'b010,
      DPSD_RUN = 3'b100
   } dpsd_state_t;
endpackage : dpsd_pkg
`default_nettype wire

// ### bench/dpsd_scan_checker.sv
// Purpose: Port timing checks for the scan drive
// Assumes: Step of 16 cycles, half step 8
// Notes: Bound after the module
`default_nettype none
module dpsd_scan_checker #(
   parameter int STEP_CYCLES = 16,
   parameter int NUM_DECADES = 3
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scan_cmd,
   input wire dpsd_pkg::dpsd_prn_t prn,
   input wire logic busy,
   input wire logic [dpsd_pkg::DECADES-1:0] drive_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Selection, arms, stepping and strobes
   a_one_enable: assert property ($onehot0(drive_enable)) else $error("two enables");
   a_arm_idle: assert property ($past(drive_enable) == 0 |-> prn.arm == 0) else $error("stray arm");
   a_idle_quiet: assert property (!busy |-> drive_enable == 0) else $error("enable idle");
   a_scan_busy: assert property ($rose(scan_cmd) |=> busy) else $error("no busy");
   a_first_step: assert property ($fell(scan_cmd) |=> drive_enable == 6'h01) else $error("no start");
   a_enable_half: assert property ($rose(drive_enable[0]) |-> drive_enable[0] [*8] ##1 !drive_enable[0])
      else $error("enable length");
   a_next_decade: assert property ($fell(drive_enable[0]) |-> ##[7:9] drive_enable[1]) else $error("order");
   a_write_pulse: assert property (prn.write |=> !prn.write) else $error("long write");
   a_print_last: assert property ($fell(drive_enable[NUM_DECADES-1]) |-> ##[1:12] prn.print)
      else $error("no print");
endmodule : dpsd_scan_checker
bind dpsd_scan_drive dpsd_scan_checker #(.STEP_CYCLES(STEP_CYCLES), .NUM_DECADES(NUM_DECADES)) chk_u (
   .clk, .sys_rst, .scan_cmd, .prn, .busy, .drive_enable);
`default_nettype wire

// ### bench/dpsd_printer.sv
// Purpose: Printer model, one digit per write strobe
// Assumes: Three decades, arms active high
// Notes: Decade 0 ends in the top ten bits
`default_nettype none
module dpsd_printer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire dpsd_pkg::dpsd_prn_t prn,
   output logic [29:0] line_r,
   output logic [7:0] prints_r
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [29:0] store_r;
   logic print_q;
   // Store arms on write, print on command rise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         store_r <= '0;
         line_r <= '0;
         prints_r <= '0;
         print_q <= 1'b0;
      end else begin
         print_q <= prn.print;
         if (prn.write) store_r <= {store_r[19:0], prn.arm};
         if (prn.print && !print_q) line_r <= store_r;
         if (prn.print && !print_q) prints_r <= prints_r + 8'h01;
      end
   end
endmodule : dpsd_printer
`default_nettype wire

// ### bench/dpsd_scan_drive_tb.sv
// Purpose: Self-checking bench for the scan drive
// Assumes: Step shortened to 16 cycles
// Notes: Results judged at the printer model
`default_nettype none
module dpsd_scan_drive_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [59:0] count_n = '1;
   logic transfer = 1'b0;
   logic buffer_bypass = 1'b0;
   logic scan_cmd = 1'b0;
   dpsd_pkg::dpsd_prn_t prn;
   logic busy;
   logic [5:0] drive_enable;
   logic [29:0] line_r;
   logic [7:0] prints_r;
   int err_total = 0;
   int total_checks = 0;
   dpsd_scan_drive #(.STEP_CYCLES(16), .NUM_DECADES(3)) dut_u (.clk, .sys_rst, .count_n, .transfer,
      .buffer_bypass, .scan_cmd, .prn, .busy, .drive_enable);
   dpsd_printer prn_u (.clk, .sys_rst, .prn, .line_r, .prints_r);
   // Clock, 100 ns
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [59:0] code(input int a, input int b, input int c);
      code = '1;
      code[a] = 1'b0;
      code[10 + b] = 1'b0;
      code[20 + c] = 1'b0;
   endfunction : code
   function automatic logic [29:0] arms(input int a, input int b, input int c);
      arms = {10'(1 << a), 10'(1 << b), 10'(1 << c)};
   endfunction : arms
   task automatic check(input string name, input logic [29:0] exp, input logic [29:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic end_of_test;
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   // One scan, then the printed line
   task automatic run_scan(input logic [29:0] exp);
      int p;
      p = prints_r;
      scan_cmd <= 1'b1;
      repeat (dpsd_pkg::SCAN_MIN_CYC) @(posedge clk);
      scan_cmd <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      check("line", exp, line_r);
      check("prints", 30'(p + 1), 30'(prints_r));
   endtask : run_scan
   // Every digit on every decade, fed straight through
   task automatic t_direct;
      buffer_bypass <= 1'b1;
      transfer <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         count_n <= code(k, (k + 3) % 10, (k + 7) % 10);
         run_scan(arms(k, (k + 3) % 10, (k + 7) % 10));
      end
      buffer_bypass <= 1'b0;
      transfer <= 1'b0;
   endtask : t_direct
   // Buffer holds while counter moves, then clears
   task automatic t_buffer;
      count_n <= code(7, 0, 9);
      @(posedge clk);
      transfer <= 1'b1;
      @(posedge clk);
      count_n <= code(2, 5, 8);
      run_scan(arms(7, 0, 9));
      transfer <= 1'b0;
      @(posedge clk);
      run_scan('0);
   endtask : t_buffer
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("reset", '0, 30'({prn, busy, drive_enable}));
      t_direct();
      t_buffer();
      end_of_test();
   end
   // Watchdog
   initial begin
      #3000000;
      err_total++;
      end_of_test();
   end
endmodule : dpsd_scan_drive_tb
`default_nettype wire
